// ### oc_thresh_cfg.svh
`ifndef OC_THRESH_CFG_SVH
`define OC_THRESH_CFG_SVH
// Linear word: 5-bit signed exponent above an 11-bit signed mantissa.
`define LIN_EXP_MSB      15
`define LIN_EXP_LSB      11
`define LIN_MAN_MSB      10
// Gain in 30.5 uOhm steps (9 bits, up to 15.6 mOhm).
`define GAIN_MAX         9'h1ff
// 3.75 mOhm expressed in 30.5 uOhm gain steps.
`define GAIN_KNEE        9'h07b
// Offset in 62.5 mA steps: signed 7 bits, -4 A .. 3.937 A.
`define OFS_MIN          (-64)
`define OFS_MAX          63
// 500 mA limit step is 8 offset steps of 62.5 mA.
`define LIMIT_STEP_SH    3
// DAC step 1.875 mV; currents are held in 62.5 mA units.
`define DAC_STEP_UV      1875
// Temperature coefficient 4000 ppm/C, applied as tc_q16 per degree.
`define TC_PPM           4000
`define TC_Q16           16'h0106
`define TEMP_REF_C       8'h19
// Soft-start choices in microseconds.
`define TON_600US        32'd600
`define TON_1500US       32'd1500
`define TON_2700US       32'd2700
`define TON_9000US       32'd9000
`define CLK_MHZ          200
// Current averaging window is 2**AVG_SH samples.
`define AVG_SH           6
`endif

// ### oc_thresh_pkg.sv
package oc_thresh_pkg;
	typedef enum logic [2:0] {
		MARGIN_OFF  = 3'b001,
		MARGIN_LOW  = 3'b010,
		MARGIN_HIGH = 3'b100
	} margin_t;
	typedef enum logic [1:0] {
		TON_SEL_600US  = 2'h0,
		TON_SEL_1500US = 2'h1,
		TON_SEL_2700US = 2'h2,
		TON_SEL_9000US = 2'h3
	} ton_sel_t;
	typedef enum logic [1:0] {
		RAMP_IDLE = 2'b01,
		RAMP_STEP = 2'b10
	} ramp_state_t;
endpackage

// ### oc_ref_ramp.sv
`timescale 1ns/10ps
`include "oc_thresh_cfg.svh"
// Steps the feedback reference code toward a target at a fixed code rate.
module oc_ref_ramp #(
	parameter int REF_W = 10
) (
	// Clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             rst_b_i,
	// Control
	input  wire logic [31:0]      step_cycles_i,
	input  wire logic [REF_W-1:0] target_i,
	// Result
	output logic      [REF_W-1:0] ref_code_o,
	output logic                  ramp_busy_o
);
	import oc_thresh_pkg::*;

	ramp_state_t state;
	logic [31:0] tick;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state       <= RAMP_IDLE;
			tick        <= 32'h0;
			ref_code_o  <= '0;
			ramp_busy_o <= 1'b0;
		end else begin
			case (state)
				RAMP_IDLE: begin
					tick <= 32'h0;
					ramp_busy_o <= (target_i != ref_code_o);
					if (target_i != ref_code_o)
						state <= RAMP_STEP;
				end
				RAMP_STEP: begin
					// One code per period: same V/s as soft-start.
					if (tick + 32'h1 >= step_cycles_i) begin
						tick <= 32'h0;
						if (target_i > ref_code_o)
							ref_code_o <= ref_code_o + 1'b1;
						else if (target_i < ref_code_o)
							ref_code_o <= ref_code_o - 1'b1;
						else begin
							state       <= RAMP_IDLE;
							ramp_busy_o <= 1'b0;
						end
					end else begin
						tick <= tick + 32'h1;
					end
				end
				default: state <= RAMP_IDLE;
			endcase
		end
	end
endmodule // oc_ref_ramp

// ### oc_threshold_config.sv
`timescale 1ns/10ps
`include "oc_thresh_cfg.svh"
module oc_threshold_config #(
	parameter int REF_W  = 10,
	parameter int SNS_W  = 12,
	parameter int DAC_W  = 10
) (
	// Clock and reset
	input  wire logic                   ref_clk_i,
	input  wire logic                   rst_b_i,
	// Configuration writes
	input  wire logic                   gain_wr_i,
	input  wire logic                   offset_wr_i,
	input  wire logic                   warn_wr_i,
	input  wire logic                   fault_wr_i,
	input  wire logic                   ton_wr_i,
	input  wire logic [15:0]            wr_data_i,
	// Margin and reference
	input  wire oc_thresh_pkg::margin_t margin_i,
	input  wire logic [REF_W-1:0]       ref_nom_i,
	input  wire logic [REF_W-1:0]       ref_high_i,
	input  wire logic [REF_W-1:0]       ref_low_i,
	input  wire logic [REF_W-1:0]       ref_span_i,
	// Analog side, sampled from pins
	input  wire logic [SNS_W-1:0]       sense_uv_i,
	input  wire logic                   sense_neg_i,
	input  wire logic [7:0]             die_temp_i,
	// Results
	output logic [DAC_W-1:0]            warn_dac_o,
	output logic [DAC_W-1:0]            fault_dac_o,
	output logic                        oc_warn_o,
	output logic                        oc_fault_o,
	output logic [15:0]                 read_iout_o,
	output logic [REF_W-1:0]            ref_code_o,
	output logic                        ramp_busy_o,
	output logic                        limit_order_err_o
);
	import oc_thresh_pkg::*;

	// Decode linear word to a value scaled by 2**sh (sh = frac bits).
	function automatic logic signed [31:0] lin_val(input logic [15:0] w,
	                                               input int sh);
		logic signed [4:0]  e;
		logic signed [31:0] m;
		int                 s;
		e = w[`LIN_EXP_MSB:`LIN_EXP_LSB];
		m = 32'(signed'(w[`LIN_MAN_MSB:0]));
		s = int'(e) + sh;
		if (s >= 0)
			lin_val = m <<< s;
		else
			lin_val = m >>> (-s);
	endfunction

	// Two-flop synchronisers for pin-side inputs.
	logic [SNS_W-1:0] sns_a, sns_b;
	logic             neg_a, neg_b;
	logic [7:0]       tmp_a, tmp_b;
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sns_a <= '0;
			sns_b <= '0;
			neg_a <= 1'b0;
			neg_b <= 1'b0;
			tmp_a <= `TEMP_REF_C;
			tmp_b <= `TEMP_REF_C;
		end else begin
			sns_a <= sense_uv_i;
			sns_b <= sns_a;
			neg_a <= sense_neg_i;
			neg_b <= neg_a;
			tmp_a <= die_temp_i;
			tmp_b <= tmp_a;
		end
	end

	// Calibration and limits; limits in 62.5 mA units.
	logic [8:0]        gain;
	logic signed [6:0] offset;
	logic [15:0]       warn_lim;
	logic [15:0]       fault_lim;
	logic              gain_set;
	logic              offset_set;
	ton_sel_t          ton_sel;
	logic signed [31:0] g_v, o_v, w_v, f_v;

	always_comb begin
		g_v = lin_val(wr_data_i, 15);
		o_v = lin_val(wr_data_i, 4);
		w_v = lin_val(wr_data_i, 1);
		f_v = w_v;
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gain       <= 9'h0;
			offset     <= 7'sh0;
			gain_set   <= 1'b0;
			offset_set <= 1'b0;
		end else begin
			if (gain_wr_i) begin
				// Ohms scaled by 2**15 gives 30.5 uOhm units.
				if (g_v < 0)
					gain <= 9'h0;
				else if (g_v > 32'(`GAIN_MAX))
					gain <= `GAIN_MAX;
				else
					gain <= g_v[8:0];
				gain_set <= 1'b1;
			end
			if (offset_wr_i) begin
				// Amps scaled by 2**4 are 62.5 mA units, truncated.
				if (o_v < `OFS_MIN)
					offset <= 7'(`OFS_MIN);
				else if (o_v > `OFS_MAX)
					offset <= 7'(`OFS_MAX);
				else
					offset <= o_v[6:0];
				offset_set <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			warn_lim          <= 16'h0;
			fault_lim         <= 16'h0;
			limit_order_err_o <= 1'b0;
		end else begin
			// Half-amp units shifted to 62.5 mA units: 500 mA grain.
			if (warn_wr_i)
				warn_lim <= (w_v < 0) ? 16'h0 :
				            16'(w_v[12:0] << `LIMIT_STEP_SH);
			if (fault_wr_i)
				fault_lim <= (f_v < 0) ? 16'h0 :
				             16'(f_v[12:0] << `LIMIT_STEP_SH);
			// Sticky flag when limits arrive before calibration.
			if ((warn_wr_i || fault_wr_i) && !(gain_set && offset_set))
				limit_order_err_o <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			ton_sel <= TON_SEL_600US;
		else if (ton_wr_i)
			ton_sel <= ton_sel_t'(wr_data_i[1:0]);
	end

	// Limit to DAC code: (I - ofs) * R / 1.875 mV, then temperature.
	function automatic logic [DAC_W-1:0] to_dac(input logic [15:0] lim,
	                                            input logic [8:0] g,
	                                            input logic signed [6:0] o,
	                                            input logic [7:0] t);
		logic signed [31:0] i;
		logic [47:0]        uv;
		logic [47:0]        code;
		logic signed [31:0] dt;
		logic [47:0]        adj;
		i = 32'(signed'({1'b0, lim})) - 32'(o);
		if (i < 0)
			i = 0;
		// 62.5 mA * 30.5 uOhm = 1.9073 uV; uses 2**-19 A*Ohm scale.
		uv = 48'(i) * 48'(g) * 48'd1000000 >> 19;
		code = uv / 48'(`DAC_STEP_UV);
		dt = 32'(t) - 32'(`TEMP_REF_C);
		if (dt < 0)
			dt = 0;
		adj = code + ((code * 48'(dt) * 48'(`TC_Q16)) >> 16);
		if (adj > 48'((1 << DAC_W) - 1))
			to_dac = '1;
		else
			to_dac = adj[DAC_W-1:0];
	endfunction

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			warn_dac_o  <= '1;
			fault_dac_o <= '1;
		end else begin
			// DAC code granularity only wins under the 3.75 mOhm knee.
			warn_dac_o  <= to_dac(warn_lim, gain, offset, tmp_b);
			fault_dac_o <= to_dac(fault_lim, gain, offset, tmp_b);
		end
	end

	// Sense reading in DAC codes, compared independently.
	logic [SNS_W-1:0] sns_code;
	always_comb sns_code = SNS_W'(32'(sns_b) / `DAC_STEP_UV);

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			oc_warn_o  <= 1'b0;
			oc_fault_o <= 1'b0;
		end else begin
			oc_warn_o  <= !neg_b && (sns_code > SNS_W'(warn_dac_o));
			oc_fault_o <= !neg_b && (sns_code > SNS_W'(fault_dac_o));
		end
	end

	// Block average of the sensed ripple; sinking clamps to zero.
	logic [SNS_W+`AVG_SH-1:0] acc;
	logic [`AVG_SH-1:0]       cnt;
	logic [31:0]              avg_ma;
	always_comb begin
		avg_ma = 32'(acc[SNS_W+`AVG_SH-1:`AVG_SH]);
		if (gain != 9'h0)
			avg_ma = 32'((64'(avg_ma) << 15) / 64'(gain) / 1000);
		else
			avg_ma = 32'h0;
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			acc         <= '0;
			cnt         <= '0;
			read_iout_o <= 16'h0;
		end else begin
			cnt <= cnt + 1'b1;
			if (cnt == '1) begin
				// Seed the next window with this sample, so every report after the
				// first spans exactly 2**AVG_SH samples.
				acc <= neg_b ? '0 : (SNS_W+`AVG_SH)'(sns_b);
				// Reported mA with offset removed, never negative.
				if (neg_b || 32'(signed'(avg_ma)) * 16 < 32'(offset) * 1000)
					read_iout_o <= 16'h0;
				else
					read_iout_o <= 16'(signed'(avg_ma) -
					               (32'(offset) * 1000 / 16));
			end else if (!neg_b) begin
				acc <= acc + (SNS_W+`AVG_SH)'(sns_b);
			end
		end
	end

	// Reference target and ramp rate tied to soft-start.
	logic [REF_W-1:0] target;
	logic [31:0]      ton_us;
	logic [31:0]      step_cycles;
	always_comb begin
		case (margin_i)
			MARGIN_HIGH: target = ref_high_i;
			MARGIN_LOW:  target = ref_low_i;
			default:     target = ref_nom_i;
		endcase
		case (ton_sel)
			TON_SEL_600US:  ton_us = `TON_600US;
			TON_SEL_1500US: ton_us = `TON_1500US;
			TON_SEL_2700US: ton_us = `TON_2700US;
			default:        ton_us = `TON_9000US;
		endcase
		// Full span in ton_us: cycles per reference code.
		step_cycles = (ton_us * `CLK_MHZ) /
		              ((ref_span_i == '0) ? 32'h1 : 32'(ref_span_i));
	end

	oc_ref_ramp #(
		.REF_W (REF_W)
	) u_ramp (
		.ref_clk_i     (ref_clk_i),
		.rst_b_i       (rst_b_i),
		.step_cycles_i (step_cycles),
		.target_i      (target),
		.ref_code_o    (ref_code_o),
		.ramp_busy_o   (ramp_busy_o)
	);
endmodule // oc_threshold_config

// ### oc_host_model.sv
`timescale 1ns/10ps
module oc_host_model (
	// Clock
	input  wire logic        ref_clk_i,
	// Command strobes and argument
	output logic             gain_wr_o,
	output logic             offset_wr_o,
	output logic             warn_wr_o,
	output logic             fault_wr_o,
	output logic             ton_wr_o,
	output logic [15:0]      wr_data_o
);
	initial begin
		{ton_wr_o, fault_wr_o, warn_wr_o, offset_wr_o, gain_wr_o} = 5'h0;
		wr_data_o = 16'h0;
	end
	function automatic logic [15:0] lin(input int man, input int ex);
		return {ex[4:0], man[10:0]};
	endfunction
	// The argument is inverted once the strobe drops so stale data is seen.
	task automatic send(input int cmd, input logic [15:0] arg);
		@(posedge ref_clk_i);
		#1;
		wr_data_o = arg;
		{ton_wr_o, fault_wr_o, warn_wr_o, offset_wr_o, gain_wr_o} = 5'h1 << cmd;
		@(posedge ref_clk_i);
		#1;
		{ton_wr_o, fault_wr_o, warn_wr_o, offset_wr_o, gain_wr_o} = 5'h0;
		wr_data_o = ~arg;
	endtask
endmodule // oc_host_model

// ### oc_threshold_config_assertions.sv
`timescale 1ns/10ps
module oc_cfg_checker #(
	parameter int REF_W = 10,
	parameter int DAC_W = 10
) (
	// Clock, reset and controls
	input wire logic                   ref_clk_i,
	input wire logic                   rst_b_i,
	input wire logic                   gain_wr_i,
	input wire logic                   offset_wr_i,
	input wire logic                   warn_wr_i,
	input wire logic                   fault_wr_i,
	input wire oc_thresh_pkg::margin_t margin_i,
	input wire logic [REF_W-1:0]       ref_nom_i,
	input wire logic [REF_W-1:0]       ref_high_i,
	input wire logic [REF_W-1:0]       ref_low_i,
	input wire logic                   sense_neg_i,
	input wire logic [7:0]             die_temp_i,
	// Results
	input wire logic [DAC_W-1:0]       warn_dac_o,
	input wire logic [DAC_W-1:0]       fault_dac_o,
	input wire logic                   oc_warn_o,
	input wire logic                   oc_fault_o,
	input wire logic [15:0]            read_iout_o,
	input wire logic [REF_W-1:0]       ref_code_o,
	input wire logic                   ramp_busy_o,
	input wire logic                   limit_order_err_o
);
	import oc_thresh_pkg::*;
	logic             cal_gain;
	logic             cal_ofs;
	logic [6:0]       sink_cnt;
	logic [3:0]       quiet_cnt;
	logic [REF_W-1:0] tgt;
	logic             bad_wr;
	assign bad_wr = (warn_wr_i | fault_wr_i) & ~(cal_gain & cal_ofs);
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cal_gain <= 1'h0;
			cal_ofs  <= 1'h0;
		end else begin
			cal_gain <= cal_gain | gain_wr_i;
			cal_ofs  <= cal_ofs | offset_wr_i;
		end
	end
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			sink_cnt <= 7'h0;
		else if (!sense_neg_i)
			sink_cnt <= 7'h0;
		else if (sink_cnt != 7'h7f)
			sink_cnt <= sink_cnt + 7'h1;
	end
	// Temperature moves thresholds too, so it restarts the quiet count.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			quiet_cnt <= 4'h0;
		else if (bad_wr | gain_wr_i | offset_wr_i | warn_wr_i | fault_wr_i
		         | $changed(die_temp_i))
			quiet_cnt <= 4'h0;
		else if (quiet_cnt != 4'hf)
			quiet_cnt <= quiet_cnt + 4'h1;
	end
	always_comb begin
		case (margin_i)
			MARGIN_HIGH: tgt = ref_high_i;
			MARGIN_LOW:  tgt = ref_low_i;
			default:     tgt = ref_nom_i;
		endcase
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_reset_vals;
		$rose(rst_b_i) |-> warn_dac_o == {DAC_W{1'h1}} && !oc_warn_o
			&& fault_dac_o == {DAC_W{1'h1}} && !oc_fault_o
			&& read_iout_o == 16'h0 && ref_code_o == {REF_W{1'h0}};
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("reset values wrong");
	property p_order_err;
		bad_wr |-> ##[1:2] limit_order_err_o;
	endproperty
	a_order_err: assert property (p_order_err)
		else $error("early limit not flagged");
	property p_err_sticky;
		limit_order_err_o |=> limit_order_err_o;
	endproperty
	a_err_sticky: assert property (p_err_sticky)
		else $error("order error cleared");
	property p_err_cause;
		$rose(limit_order_err_o) |-> $past(bad_wr) || $past(bad_wr, 2);
	endproperty
	a_err_cause: assert property (p_err_cause)
		else $error("order error without cause");
	property p_ramp_start;
		$changed(tgt) && tgt != ref_code_o |-> ##[1:2] ramp_busy_o;
	endproperty
	a_ramp_start: assert property (p_ramp_start)
		else $error("ramp did not start");
	property p_ramp_step;
		$changed(ref_code_o) |-> ref_code_o == $past(ref_code_o) + 1'h1
			|| ref_code_o == $past(ref_code_o) - 1'h1;
	endproperty
	a_ramp_step: assert property (p_ramp_step)
		else $error("reference jumped");
	property p_dac_hold;
		quiet_cnt >= 4'h8 |-> $stable(warn_dac_o) && $stable(fault_dac_o);
	endproperty
	a_dac_hold: assert property (p_dac_hold)
		else $error("threshold moved without cause");
	property p_sink_flags;
		sink_cnt >= 7'h5 |-> !oc_warn_o && !oc_fault_o;
	endproperty
	a_sink_flags: assert property (p_sink_flags)
		else $error("flag set while sinking");
	property p_sink_iout;
		sink_cnt >= 7'h48 |-> read_iout_o == 16'h0;
	endproperty
	a_sink_iout: assert property (p_sink_iout)
		else $error("current reported while sinking");
	c_order: cover property ($rose(limit_order_err_o));
	c_warn: cover property (oc_warn_o && !oc_fault_o);
	c_ramp: cover property ($fell(ramp_busy_o));
endmodule // oc_cfg_checker
bind oc_threshold_config oc_cfg_checker #(.REF_W(REF_W), .DAC_W(DAC_W)) chk_i (
	.ref_clk_i, .rst_b_i, .gain_wr_i, .offset_wr_i, .warn_wr_i, .fault_wr_i,
	.margin_i, .ref_nom_i, .ref_high_i, .ref_low_i, .sense_neg_i,
	.die_temp_i, .warn_dac_o, .fault_dac_o, .oc_warn_o, .oc_fault_o,
	.read_iout_o, .ref_code_o, .ramp_busy_o, .limit_order_err_o);

// ### test_overcurrent_threshold_config.sv
`timescale 1ns/10ps
module test_overcurrent_threshold_config;
	import oc_thresh_pkg::*;
	wire logic        gain_wr_i, offset_wr_i, warn_wr_i, fault_wr_i, ton_wr_i;
	wire logic [15:0] wr_data_i;
	logic             ref_clk_i = 1'h0;
	logic             rst_b_i = 1'h0;
	margin_t          margin_i = MARGIN_OFF;
	// Margins stay within a quarter of the nominal code.
	logic [9:0]       ref_nom_i = 10'h010;
	logic [9:0]       ref_high_i = 10'h012;
	logic [9:0]       ref_low_i = 10'h00e;
	logic [9:0]       ref_span_i = 10'h3ff;
	logic [11:0]      sense_uv_i = 12'h0;
	logic             sense_neg_i = 1'h0;
	logic             rip = 1'h0;
	logic [7:0]       die_temp_i = 8'h19;
	logic [9:0]       warn_dac_o, fault_dac_o, ref_code_o, d1;
	logic             oc_warn_o, oc_fault_o, ramp_busy_o, limit_order_err_o;
	logic [15:0]      read_iout_o;
	int               err_total = 0;
	int               comparisons = 0;
	int               n;
	int               t [4];
	always #2.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) if (rip) sense_uv_i <= #1 ~sense_uv_i;
	oc_host_model host (.ref_clk_i, .gain_wr_o(gain_wr_i),
		.offset_wr_o(offset_wr_i), .warn_wr_o(warn_wr_i),
		.fault_wr_o(fault_wr_i), .ton_wr_o(ton_wr_i), .wr_data_o(wr_data_i));
	oc_threshold_config dut (.ref_clk_i, .rst_b_i, .gain_wr_i, .offset_wr_i,
		.warn_wr_i, .fault_wr_i, .ton_wr_i, .wr_data_i, .margin_i, .ref_nom_i,
		.ref_high_i, .ref_low_i, .ref_span_i, .sense_uv_i, .sense_neg_i,
		.die_temp_i, .warn_dac_o, .fault_dac_o, .oc_warn_o, .oc_fault_o,
		.read_iout_o, .ref_code_o, .ramp_busy_o, .limit_order_err_o);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask
	// Bounded wait for the ramp; n holds the cycles it took.
	task automatic settle;
		cyc(2);
		n = 2;
		while (ramp_busy_o === 1'h1 && n < 30000) begin
			cyc(1);
			n++;
		end
		chk(ramp_busy_o, 1'h0);
	endtask
	task automatic restart;
		rst_b_i = 1'h0;
		cyc(10);
		rst_b_i = 1'h1;
	endtask
	initial begin
		restart;
		chk({warn_dac_o, fault_dac_o}, 20'hfffff);
		chk({oc_warn_o, oc_fault_o, read_iout_o, ref_code_o}, 28'h0);
		host.send(3, host.lin(2, 0));
		cyc(3);
		chk(limit_order_err_o, 1'h1);
		restart;
		chk(limit_order_err_o, 1'h0);
		host.send(4, 16'h0);
		settle;
		chk(ref_code_o, ref_nom_i);
		// Sense 3.05 mOhm, then the limits; fault 20 A stays under 110 mV hot.
		host.send(0, host.lin(100, -15));
		host.send(1, host.lin(0, 0));
		host.send(2, host.lin(0, 0));
		host.send(3, host.lin(20, 0));
		cyc(6);
		chk(limit_order_err_o, 1'h0);
		chk(warn_dac_o, 10'h0);
		chk(fault_dac_o >= 10'h20 && fault_dac_o <= 10'h21, 1'h1);
		sense_uv_i = 12'hfff;
		cyc(6);
		chk({oc_warn_o, oc_fault_o}, 2'h2);
		rip = 1'h1;
		cyc(200);
		chk(read_iout_o >= 16'h26c && read_iout_o <= 16'h2d0, 1'h1);
		sense_neg_i = 1'h1;
		cyc(80);
		chk({read_iout_o, oc_warn_o, oc_fault_o}, 18'h0);
		{sense_neg_i, rip} = 2'h0;
		die_temp_i = 8'h7d;
		cyc(10);
		chk(fault_dac_o >= 10'h2c && fault_dac_o <= 10'h2e, 1'h1);
		die_temp_i = 8'h19;
		host.send(0, host.lin(511, -15));
		host.send(3, host.lin(1, 0));
		cyc(6);
		d1 = fault_dac_o;
		host.send(3, host.lin(77, -6));
		cyc(6);
		chk(fault_dac_o, d1);
		host.send(3, host.lin(4, -2));
		cyc(6);
		chk(fault_dac_o, d1);
		host.send(3, host.lin(3, -1));
		cyc(6);
		chk(fault_dac_o != d1, 1'h1);
		d1 = fault_dac_o;
		host.send(1, host.lin(16, -4));
		cyc(6);
		chk(fault_dac_o != d1, 1'h1);
		host.send(3, host.lin(0, 0));
		sense_uv_i = 12'hfff;
		cyc(6);
		chk({oc_warn_o, oc_fault_o}, 2'h3);
		sense_uv_i = 12'h0;
		cyc(6);
		chk({oc_warn_o, oc_fault_o}, 2'h0);
		for (int k = 0; k < 4; k++) begin
			host.send(4, 16'(k));
			margin_i = MARGIN_HIGH;
			settle;
			t[k] = n;
			chk(ref_code_o, ref_high_i);
			margin_i = MARGIN_OFF;
			settle;
		end
		// Two codes at 600 us per span, plus one step to confirm arrival.
		chk(t[0] >= 234 && t[0] <= 360, 1'h1);
		chk(t[3] > 10 * t[0] && t[2] > t[1] && t[1] > t[0], 1'h1);
		margin_i = MARGIN_LOW;
		settle;
		chk(ref_code_o, ref_low_i);
		tally_and_finish;
	end
	initial begin
		repeat (95000) @(posedge ref_clk_i);
		err_total++;
		tally_and_finish;
	end
endmodule // test_overcurrent_threshold_config
